/* dv/pibi_ctl_model.sv */
// peripheral controller model on the programmed i/o bus
`timescale 1ns/10ps
`default_nettype none
module pibi_ctl_model #(
  parameter logic [5:0] DEV_ADDR = 6'h2a
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] eb_o,
  input wire logic eb_oe,
  input wire logic select_strobe,
  input wire logic data_strobe,
  input wire logic system_init_line,
  input wire logic access_acknowledge,
  input wire logic slow,
  input wire logic [7:0] cond,
  input wire logic [15:0] in_word,
  output logic [15:0] drv_d,
  output logic drv_en,
  output logic sense_response,
  output logic [15:0] exc_word,
  output logic [15:0] out_word,
  output logic [1:0] flags_q
);
  logic sel_q, ds_q, hit;
  logic [15:0] cap_q, dcap_q;
  logic [7:0] cnt_q;
  assign hit = cap_q[5:0] == DEV_ADDR && !access_acknowledge;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {sel_q, ds_q, cap_q, dcap_q, cnt_q, exc_word, out_word, flags_q} <= '0;
    end else if (system_init_line) begin
      {sel_q, ds_q, cap_q, dcap_q, cnt_q, exc_word, out_word, flags_q} <= '0;
    end else begin
      sel_q <= select_strobe;
      ds_q <= data_strobe;
      cnt_q <= (sel_q != select_strobe) ? 8'h00 : cnt_q + 8'h01;
      if (select_strobe) cap_q <= eb_o;
      if (data_strobe) dcap_q <= eb_o;
      if (sel_q && !select_strobe && hit) begin
        if (cap_q[11] || cap_q[15]) exc_word <= cap_q;
        flags_q <= {cap_q[14], cap_q[13]};
      end
      if (ds_q && !data_strobe) begin
        if (flags_q[1]) out_word <= dcap_q;
        flags_q <= 2'h0;
      end
    end
  end
  // slow mode waits 300 ns, still inside the 480 ns window
  assign drv_en = flags_q[0] && (!slow || cnt_q >= 8'h1e);
  // a released bus shows the inverse so a stale sample never matches
  assign drv_d = drv_en ? in_word : ~in_word;
  // answers from the address decode and the cond bit picked by lines 6 to 8, line 12 is not needed
  assign sense_response = eb_oe && eb_o[5:0] == DEV_ADDR && !access_acknowledge
    && cond[eb_o[8:6]] && (!slow || (select_strobe && cnt_q >= 8'h14));
endmodule : pibi_ctl_model
`default_nettype wire

/* dv/pibi_top_bench.sv */
// self-checking bench for the programmed i/o bus sequencer
`timescale 1ns/10ps
`default_nettype none
module pibi_top_bench;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, eb_oe, sel, dstb, sense, init, ack, drv_en, slow;
  logic [7:0] awaddr, araddr, cond;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, flags;
  logic [15:0] eb_i, eb_o, drv_d, in_word, exc_word, out_word;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [5:0] DEV = 6'h2a;
  always #5 clk = ~clk;
  assign eb_i = eb_oe ? eb_o : drv_d;
  pibi_top dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eb_i(eb_i), .eb_o(eb_o), .eb_oe(eb_oe), .select_strobe(sel), .data_strobe(dstb),
    .sense_response(sense), .system_init_line(init), .access_acknowledge(ack));
  pibi_ctl_model #(.DEV_ADDR(DEV)) model_u (.clk(clk), .rst_n(rst_n), .eb_o(eb_o),
    .eb_oe(eb_oe), .select_strobe(sel), .data_strobe(dstb), .system_init_line(init),
    .access_acknowledge(ack), .slow(slow), .cond(cond), .in_word(in_word), .drv_d(drv_d),
    .drv_en(drv_en), .sense_response(sense), .exc_word(exc_word), .out_word(out_word),
    .flags_q(flags));
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task stop_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = pibi_pkg::RESP_OKAY);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask : wr
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    {rd, rr} = {rdata, rresp};
    rready <= 1'b0;
  endtask : rd_reg
  task run(input pibi_pkg::pibi_op_t op, input logic [2:0] f, input logic [5:0] a);
    int n;
    n = 0;
    wr(pibi_pkg::REG_CMD, 32'({op, f, a}));
    repeat (3) @(posedge clk);
    do begin
      rd_reg(pibi_pkg::REG_STATUS);
      n++;
    end while (rd[pibi_pkg::ST_BUSY_BIT] !== 1'b0 && n < 100);
    chk("busy", 32'(rd[pibi_pkg::ST_BUSY_BIT]), 32'h0);
    chk("done", 32'(rd[pibi_pkg::ST_DONE_BIT]), 32'h1);
  endtask : run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    clk = 1'b0;
    {rst_n, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {awaddr, araddr, wdata, wstrb, cond, in_word} = {48'h0, 4'hf, 8'h20, 16'h0f0f};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(pibi_pkg::REG_ACC);
    chk("acc reset", rd, 32'(pibi_pkg::ACC_RESET));
    rd_reg(8'h40);
    chk("unmapped", 32'(rr), 32'(pibi_pkg::RESP_SLVERR));
    // an operation code beyond the five defined ones is refused
    wr(pibi_pkg::REG_CMD, 32'h0e00, pibi_pkg::RESP_SLVERR);
    for (int i = 0; i < 2; i++) begin
      run(i ? pibi_pkg::PIBI_OP_EXC2 : pibi_pkg::PIBI_OP_EXC, 3'h5, DEV);
      chk("exc word", 32'(exc_word), 32'h16a | (32'h1 << (i ? 15 : 11)));
      chk("exc flags", 32'(flags), 32'h0);
    end
    wr(pibi_pkg::REG_STATUS, 32'h2);
    rd_reg(pibi_pkg::REG_STATUS);
    chk("done clear", 32'(rd[pibi_pkg::ST_DONE_BIT]), 32'h0);
    // true, false and foreign address, each prompt and slow
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      run(pibi_pkg::PIBI_OP_SENSE, i[1] ? 3'h4 : 3'h5, i[2] ? 6'h15 : DEV);
      chk("jump", 32'(rd[pibi_pkg::ST_JUMP_BIT]), 32'(!i[1] && !i[2]));
      chk("sense bit", 32'(rd[pibi_pkg::ST_SENSE_BIT]), 32'(!i[1] && !i[2]));
    end
    wr(pibi_pkg::REG_ACC, 32'h00f0);
    slow <= 1'b0;
    run(pibi_pkg::PIBI_OP_IN, 3'h0, DEV);
    rd_reg(pibi_pkg::REG_ACC);
    chk("acc or", rd, 32'h0fff);
    {slow, in_word} <= {1'b1, 16'h3300};
    run(pibi_pkg::PIBI_OP_IN, 3'h4, DEV);
    rd_reg(pibi_pkg::REG_ACC);
    chk("acc clear", rd, 32'h3300);
    chk("in flag", 32'(flags), 32'h0);
    wr(pibi_pkg::REG_ODATA, 32'ha5c3);
    run(pibi_pkg::PIBI_OP_OUT, 3'h0, DEV);
    chk("out word", 32'(out_word), 32'ha5c3);
    // acknowledge blocks the decode, so the control word is ignored
    wr(pibi_pkg::REG_CTRL, 32'h2);
    chk("ack line", 32'(ack), 32'h1);
    run(pibi_pkg::PIBI_OP_EXC, 3'h2, DEV);
    chk("ack exc", 32'(exc_word), 32'h816a);
    wr(pibi_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("init clear", 32'(out_word), 32'h0);
    wr(pibi_pkg::REG_CTRL, 32'h0);
    stop_test();
  end
endmodule : pibi_top_bench
`default_nettype wire

/* rtl/pibi_pkg.sv */
// constants, register map and state carriers for the programmed i/o bus master
package pibi_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_ODATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;
  // command word fields
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_FUNC_LSB = 6;
  localparam int CMD_OP_LSB = 9;
  // status and control bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_JUMP_BIT = 2;
  localparam int ST_SENSE_BIT = 3;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_ACK_BIT = 1;
  // e bus line positions
  localparam int EB_FUNC_LSB = 6;
  localparam int EB_CLEAR_BIT = 8;
  localparam int EB_EXC_BIT = 11;
  localparam int EB_SENSE_BIT = 12;
  localparam int EB_IN_BIT = 13;
  localparam int EB_OUT_BIT = 14;
  localparam int EB_EXC2_BIT = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] ACC_RESET = 16'h0000;
  // times in ns; select edges and the sense sample count from the start of the execute phase
  localparam int SEL_ON_NS = 100;
  localparam int SEL_OFF_NS = 400;
  localparam int HOLD_NS = 50;
  localparam int SENSE_NS = 410;
  localparam int DATA_WAIT_NS = 480;
  localparam int DSTB_NS = 200;
  // cycle counts: least times round up, the latest sense sample rounds down
  localparam logic [7:0] SEL_ON_CYC = 8'((SEL_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SEL_OFF_CYC = 8'((SEL_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYC = 8'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SENSE_CYC = 8'(SENSE_NS / CLK_PERIOD_NS);
  localparam logic [7:0] DSTB_ON_CYC =
    8'((SEL_OFF_NS + DATA_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] DSTB_OFF_CYC = 8'(DSTB_ON_CYC + (DSTB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] TMR_RESET = 8'h00;

  typedef enum logic [2:0] {
    PIBI_OP_EXC = 3'h0,
    PIBI_OP_EXC2 = 3'h1,
    PIBI_OP_SENSE = 3'h2,
    PIBI_OP_IN = 3'h3,
    PIBI_OP_OUT = 3'h4
  } pibi_op_t;

  typedef enum logic [2:0] {
    PIBI_ST_IDLE = 3'h0,
    PIBI_ST_SEL = 3'h1,
    PIBI_ST_GAP = 3'h2,
    PIBI_ST_DATA = 3'h3,
    PIBI_ST_END = 3'h4
  } pibi_fsm_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
  } pibi_axi_t;

  typedef struct packed {
    pibi_axi_t axi;
    pibi_fsm_t fsm;
    pibi_op_t op;
    logic [5:0] addr;
    logic [2:0] func;
    logic [15:0] acc;
    logic [15:0] odata;
    logic [15:0] eb_o;
    logic eb_oe;
    logic sel;
    logic dstb;
    logic sense_seen;
    logic jump;
    logic done;
    logic init;
    logic ack;
    logic tclr;
  } pibi_state_t;
endpackage : pibi_pkg

/* rtl/pibi_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pibi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pibi_sync_t;
  pibi_sync_t st_q;
  pibi_sync_t st_d;
  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign q = st_q.s2;
endmodule : pibi_sync
`default_nettype wire

/* rtl/pibi_tmr.sv */
// elapsed-cycle counter measured from the start of the execute phase
`timescale 1ns/10ps
`default_nettype none
module pibi_tmr (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  output logic [7:0] elapsed
);
  typedef struct packed {
    logic [7:0] cnt;
  } pibi_tmr_t;
  pibi_tmr_t st_q;
  pibi_tmr_t st_d;
  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.cnt = pibi_pkg::TMR_RESET;
    end else if (st_q.cnt != 8'hff) begin
      // saturates so a stuck sequence cannot wrap into an early strobe
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.cnt <= pibi_pkg::TMR_RESET;
    end else begin
      st_q <= st_d;
    end
  end
  assign elapsed = st_q.cnt;
endmodule : pibi_tmr
`default_nettype wire

/* rtl/pibi_top.sv */
// computer-side programmed i/o bus sequencer with an axi4-lite register slave
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pibi_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] eb_i,
  output logic [15:0] eb_o,
  output logic eb_oe,
  output logic select_strobe,
  output logic data_strobe,
  input wire logic sense_response,
  output logic system_init_line,
  output logic access_acknowledge
);
  pibi_pkg::pibi_state_t st_q;
  pibi_pkg::pibi_state_t st_d;
  logic [15:0] eb_s;
  logic sense_s;
  logic [7:0] t;
  logic [31:0] wmask;
  logic [31:0] wmerge;
  logic [31:0] rd_val;
  logic rd_err;
  logic do_wr;
  logic busy;
  logic is_ctrl_op;

  pibi_sync #(.W(16)) u_sync_eb (
    .clk(clk),
    .rst_n(rst_n),
    .d(eb_i),
    .q(eb_s)
  );
  pibi_sync #(.W(1)) u_sync_sense (
    .clk(clk),
    .rst_n(rst_n),
    .d(sense_response),
    .q(sense_s)
  );
  pibi_tmr u_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .clr(st_q.tclr),
    .elapsed(t)
  );

  assign busy = (st_q.fsm != pibi_pkg::PIBI_ST_IDLE);
  assign is_ctrl_op = (st_q.op == pibi_pkg::PIBI_OP_EXC) || (st_q.op == pibi_pkg::PIBI_OP_EXC2)
    || (st_q.op == pibi_pkg::PIBI_OP_SENSE);

  always_comb begin
    st_d = st_q;
    wmask = {{8{st_q.axi.w_strb[3]}}, {8{st_q.axi.w_strb[2]}},
             {8{st_q.axi.w_strb[1]}}, {8{st_q.axi.w_strb[0]}}};
    wmerge = 32'h00000000;
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    do_wr = st_q.axi.aw_have && st_q.axi.w_have && !st_q.axi.bvalid;

    // write channels are taken independently, in either order
    if (s_axi_awvalid && st_q.axi.awready) begin
      st_d.axi.aw_have = 1'b1;
      st_d.axi.aw_addr = s_axi_awaddr;
      st_d.axi.awready = 1'b0;
    end
    if (s_axi_wvalid && st_q.axi.wready) begin
      st_d.axi.w_have = 1'b1;
      st_d.axi.w_data = s_axi_wdata;
      st_d.axi.w_strb = s_axi_wstrb;
      st_d.axi.wready = 1'b0;
    end
    if (st_q.axi.bvalid && s_axi_bready) begin
      st_d.axi.bvalid = 1'b0;
      st_d.axi.awready = 1'b1;
      st_d.axi.wready = 1'b1;
    end

    // sequencer
    st_d.tclr = 1'b0;
    case (st_q.fsm)
      pibi_pkg::PIBI_ST_IDLE: begin
        st_d.tclr = 1'b1;
        st_d.eb_oe = 1'b0;
        st_d.sel = 1'b0;
        st_d.dstb = 1'b0;
      end
      pibi_pkg::PIBI_ST_SEL: begin
        st_d.sel = (t >= pibi_pkg::SEL_ON_CYC) && (t < pibi_pkg::SEL_OFF_CYC);
        if (st_q.op == pibi_pkg::PIBI_OP_SENSE && t == pibi_pkg::SENSE_CYC) begin
          st_d.sense_seen = sense_s;
          st_d.jump = sense_s;
        end
        if (t == pibi_pkg::SEL_OFF_CYC + pibi_pkg::HOLD_CYC) begin
          if (is_ctrl_op) begin
            st_d.fsm = pibi_pkg::PIBI_ST_END;
          end else begin
            st_d.fsm = pibi_pkg::PIBI_ST_GAP;
            // address withdrawn after its hold; output word then takes the bus
            st_d.eb_oe = (st_q.op == pibi_pkg::PIBI_OP_OUT);
            st_d.eb_o = (st_q.op == pibi_pkg::PIBI_OP_OUT) ? st_q.odata : 16'h0000;
          end
        end
      end
      pibi_pkg::PIBI_ST_GAP: begin
        // waiting covers the controller's 480ns to drive input data
        if (t == pibi_pkg::DSTB_ON_CYC) begin
          st_d.dstb = 1'b1;
          st_d.fsm = pibi_pkg::PIBI_ST_DATA;
        end
      end
      pibi_pkg::PIBI_ST_DATA: begin
        if (t == pibi_pkg::DSTB_OFF_CYC) begin
          st_d.dstb = 1'b0;
          st_d.fsm = pibi_pkg::PIBI_ST_END;
          if (st_q.op == pibi_pkg::PIBI_OP_IN) begin
            // every input variant shares this path; only the clear bit differs
            st_d.acc = (st_q.func[2] ? 16'h0000 : st_q.acc) | eb_s;
          end
        end
      end
      pibi_pkg::PIBI_ST_END: begin
        st_d.eb_oe = 1'b0;
        st_d.eb_o = 16'h0000;
        st_d.done = 1'b1;
        st_d.fsm = pibi_pkg::PIBI_ST_IDLE;
      end
      default: begin
        st_d.fsm = pibi_pkg::PIBI_ST_IDLE;
      end
    endcase

    // register writes
    if (do_wr) begin
      st_d.axi.bvalid = 1'b1;
      st_d.axi.bresp = pibi_pkg::RESP_OKAY;
      if (st_q.axi.aw_addr == pibi_pkg::REG_CMD) begin
        wmerge = st_q.axi.w_data & wmask;
        if (busy || wmerge[pibi_pkg::CMD_OP_LSB +: 3] > 3'(pibi_pkg::PIBI_OP_OUT)) begin
          st_d.axi.bresp = pibi_pkg::RESP_SLVERR;
        end else begin
          st_d.op = pibi_pkg::pibi_op_t'(wmerge[pibi_pkg::CMD_OP_LSB +: 3]);
          st_d.addr = wmerge[pibi_pkg::CMD_ADDR_LSB +: 6];
          st_d.func = wmerge[pibi_pkg::CMD_FUNC_LSB +: 3];
          st_d.jump = 1'b0;
          st_d.sense_seen = 1'b0;
          st_d.fsm = pibi_pkg::PIBI_ST_SEL;
          st_d.eb_oe = 1'b1;
          st_d.eb_o = 16'h0000;
          st_d.eb_o[5:0] = wmerge[pibi_pkg::CMD_ADDR_LSB +: 6];
          st_d.eb_o[pibi_pkg::EB_FUNC_LSB +: 3] = wmerge[pibi_pkg::CMD_FUNC_LSB +: 3];
          case (pibi_pkg::pibi_op_t'(wmerge[pibi_pkg::CMD_OP_LSB +: 3]))
            pibi_pkg::PIBI_OP_EXC: st_d.eb_o[pibi_pkg::EB_EXC_BIT] = 1'b1;
            pibi_pkg::PIBI_OP_EXC2: st_d.eb_o[pibi_pkg::EB_EXC2_BIT] = 1'b1;
            pibi_pkg::PIBI_OP_SENSE: st_d.eb_o[pibi_pkg::EB_SENSE_BIT] = 1'b1;
            pibi_pkg::PIBI_OP_IN: st_d.eb_o[pibi_pkg::EB_IN_BIT] = 1'b1;
            default: st_d.eb_o[pibi_pkg::EB_OUT_BIT] = 1'b1;
          endcase
        end
      end else if (st_q.axi.aw_addr == pibi_pkg::REG_ACC) begin
        wmerge = ({16'h0000, st_q.acc} & ~wmask) | (st_q.axi.w_data & wmask);
        st_d.acc = wmerge[15:0];
      end else if (st_q.axi.aw_addr == pibi_pkg::REG_ODATA) begin
        wmerge = ({16'h0000, st_q.odata} & ~wmask) | (st_q.axi.w_data & wmask);
        st_d.odata = wmerge[15:0];
      end else if (st_q.axi.aw_addr == pibi_pkg::REG_STATUS) begin
        // write one clears done; a completion in the same cycle still wins
        if (st_q.axi.w_strb[0] && st_q.axi.w_data[pibi_pkg::ST_DONE_BIT]
            && st_q.fsm != pibi_pkg::PIBI_ST_END) begin
          st_d.done = 1'b0;
        end
      end else if (st_q.axi.aw_addr == pibi_pkg::REG_CTRL) begin
        if (st_q.axi.w_strb[0]) begin
          st_d.init = st_q.axi.w_data[pibi_pkg::CTRL_INIT_BIT];
          st_d.ack = st_q.axi.w_data[pibi_pkg::CTRL_ACK_BIT];
        end
      end else begin
        st_d.axi.bresp = pibi_pkg::RESP_SLVERR;
      end
      st_d.axi.aw_have = 1'b0;
      st_d.axi.w_have = 1'b0;
    end

    // register reads; the answer stands until rready takes it
    if (st_q.axi.rvalid && s_axi_rready) begin
      st_d.axi.rvalid = 1'b0;
      st_d.axi.arready = 1'b1;
    end
    if (s_axi_arvalid && st_q.axi.arready) begin
      if (s_axi_araddr == pibi_pkg::REG_CMD) begin
        rd_val[pibi_pkg::CMD_ADDR_LSB +: 6] = st_q.addr;
        rd_val[pibi_pkg::CMD_FUNC_LSB +: 3] = st_q.func;
        rd_val[pibi_pkg::CMD_OP_LSB +: 3] = st_q.op;
      end else if (s_axi_araddr == pibi_pkg::REG_ACC) begin
        rd_val[15:0] = st_q.acc;
      end else if (s_axi_araddr == pibi_pkg::REG_ODATA) begin
        rd_val[15:0] = st_q.odata;
      end else if (s_axi_araddr == pibi_pkg::REG_STATUS) begin
        rd_val[pibi_pkg::ST_BUSY_BIT] = busy;
        rd_val[pibi_pkg::ST_DONE_BIT] = st_q.done;
        rd_val[pibi_pkg::ST_JUMP_BIT] = st_q.jump;
        rd_val[pibi_pkg::ST_SENSE_BIT] = st_q.sense_seen;
      end else if (s_axi_araddr == pibi_pkg::REG_CTRL) begin
        rd_val[pibi_pkg::CTRL_INIT_BIT] = st_q.init;
        rd_val[pibi_pkg::CTRL_ACK_BIT] = st_q.ack;
      end else begin
        rd_err = 1'b1;
      end
      st_d.axi.arready = 1'b0;
      st_d.axi.rvalid = 1'b1;
      st_d.axi.rdata = rd_val;
      st_d.axi.rresp = rd_err ? pibi_pkg::RESP_SLVERR : pibi_pkg::RESP_OKAY;
    end
  end

  // a reset in mid-transfer drops both strobes at once, so a pulse in progress reaches a controller cut short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.axi.awready <= 1'b1;
      st_q.axi.wready <= 1'b1;
      st_q.axi.arready <= 1'b1;
      st_q.acc <= pibi_pkg::ACC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = st_q.axi.awready;
  assign s_axi_wready = st_q.axi.wready;
  assign s_axi_bvalid = st_q.axi.bvalid;
  assign s_axi_bresp = st_q.axi.bresp;
  assign s_axi_arready = st_q.axi.arready;
  assign s_axi_rvalid = st_q.axi.rvalid;
  assign s_axi_rdata = st_q.axi.rdata;
  assign s_axi_rresp = st_q.axi.rresp;
  assign eb_o = st_q.eb_o;
  assign eb_oe = st_q.eb_oe;
  assign select_strobe = st_q.sel;
  assign data_strobe = st_q.dstb;
  assign system_init_line = st_q.init;
  assign access_acknowledge = st_q.ack;

  // phase one: a select pulse that has just ended
  sequence seq_sel_fall;
    st_q.sel ##1 !st_q.sel;
  endsequence
  // phase two: the output word alone on the bus, data strobe not yet up
  sequence seq_out_word;
    st_q.eb_oe && (st_q.eb_o == st_q.odata) && !st_q.dstb;
  endsequence

  property p_no_overlap;
    @(posedge clk) disable iff (!rst_n) !(st_q.sel && st_q.dstb);
  endproperty
  property p_exc_lines;
    @(posedge clk) disable iff (!rst_n) (st_q.sel && st_q.op == pibi_pkg::PIBI_OP_EXC)
      |-> (st_q.eb_oe && st_q.eb_o[pibi_pkg::EB_EXC_BIT] && !st_q.eb_o[pibi_pkg::EB_EXC2_BIT]);
  endproperty
  property p_exc2_lines;
    @(posedge clk) disable iff (!rst_n) (st_q.sel && st_q.op == pibi_pkg::PIBI_OP_EXC2)
      |-> (st_q.eb_oe && st_q.eb_o[pibi_pkg::EB_EXC2_BIT] && !st_q.eb_o[pibi_pkg::EB_EXC_BIT]);
  endproperty
  property p_sense_lines;
    @(posedge clk) disable iff (!rst_n) (st_q.sel && st_q.op == pibi_pkg::PIBI_OP_SENSE)
      |-> (st_q.eb_o[pibi_pkg::EB_SENSE_BIT] && st_q.eb_o[5:0] == st_q.addr);
  endproperty
  property p_in_lines;
    @(posedge clk) disable iff (!rst_n) (st_q.sel && st_q.op == pibi_pkg::PIBI_OP_IN)
      |-> (st_q.eb_oe && st_q.eb_o[pibi_pkg::EB_IN_BIT]);
  endproperty
  property p_out_lines;
    @(posedge clk) disable iff (!rst_n) (st_q.sel && st_q.op == pibi_pkg::PIBI_OP_OUT)
      |-> (st_q.eb_oe && st_q.eb_o[pibi_pkg::EB_OUT_BIT]);
  endproperty
  property p_ctrl_no_data;
    @(posedge clk) disable iff (!rst_n) (busy && is_ctrl_op) |-> !st_q.dstb;
  endproperty
  property p_out_word;
    @(posedge clk) disable iff (!rst_n)
      (seq_sel_fall ##0 st_q.op == pibi_pkg::PIBI_OP_OUT) |-> ##[1:20] seq_out_word;
  endproperty
  property p_sense_only;
    @(posedge clk) disable iff (!rst_n) (st_q.op != pibi_pkg::PIBI_OP_SENSE) |-> !st_q.sense_seen;
  endproperty

  AST_STROBE_NO_OVERLAP: assert property (p_no_overlap)
    else $error("select and data strobes overlap");
  AST_EXC_LINES: assert property (p_exc_lines)
    else $error("control select without line 11");
  AST_EXC2_LINES: assert property (p_exc2_lines)
    else $error("extended control select without line 15 alone");
  AST_SENSE_LINES: assert property (p_sense_lines)
    else $error("sense select without line 12 and address");
  AST_IN_LINES: assert property (p_in_lines)
    else $error("input select without line 13");
  AST_OUT_LINES: assert property (p_out_lines)
    else $error("output select without line 14");
  AST_CTRL_NO_DATA: assert property (p_ctrl_no_data)
    else $error("data strobe during a control or sense operation");
  AST_OUT_WORD: assert property (p_out_word)
    else $error("output word not on the bus after select");
  AST_SENSE_ONLY: assert property (p_sense_only)
    else $error("sense result held outside a sense operation");
endmodule : pibi_top
`default_nettype wire
